// ===== ncid_regs.svh
// Constants of the nibble CPU instruction decoder
`ifndef NCID_REGS_SVH
`define NCID_REGS_SVH
// ********************************************
// Register offsets (byte addresses)
// ********************************************
`define NCID_OFS_CTRL    8'h00
`define NCID_OFS_PORTDIR 8'h04
`define NCID_OFS_TIMER   8'h08
`define NCID_OFS_STATUS  8'h0C
// ********************************************
// Reset values
// ********************************************
`define NCID_PC_RST      12'h000
`define NCID_LVD_RST     4'h5
// ********************************************
// Sequencer phases of one instruction cycle
// ********************************************
`define NCID_PH_LATCH    2'h1
`define NCID_PH_EXEC     2'h3
// ********************************************
// Opcodes (top five bits), wider codes and prefixes, fixed words and BCD constants
// ********************************************
`define NCID_OP_ADC      5'h00
`define NCID_OP_ADD      5'h01
`define NCID_OP_SUBC     5'h02
`define NCID_OP_SUB      5'h03
`define NCID_OP_XOR      5'h04
`define NCID_OP_OR       5'h05
`define NCID_OP_AND      5'h06
`define NCID_OP_LDST     5'h07
`define NCID_OP_ADDI     5'h08
`define NCID_OP_ADIM     5'h09
`define NCID_OP_SUBI     5'h0A
`define NCID_OP_SBIM     5'h0B
`define NCID_OP_XORI     5'h0C
`define NCID_OP_ORI      5'h0D
`define NCID_OP_ANDI     5'h0E
`define NCID_OP_LDIMM    5'h0F
`define NCID_OP_BRNZ     5'h10
`define NCID_OP_BRNC     5'h11
`define NCID_OP_BRZ      5'h12
`define NCID_OP_BRC      5'h13
`define NCID_OP_CALL     5'h18
`define NCID_OP_RET      5'h1A
`define NCID_DECA_CODE   9'h196
`define NCID_DECS_CODE   9'h19A
`define NCID_W_SHRT      16'hF000
`define NCID_W_RETI      16'hD400
`define NCID_W_HALT      16'hD800
`define NCID_W_STOP      16'hDC00
`define NCID_W_TABJ      16'hF7FF
`define NCID_JUMP_PFX    4'hE
`define NCID_BIT_PFX     3'h5
`define NCID_BCD_MAX     4'h9
`define NCID_BCD_ADJ     4'h6
`endif

// ===== ncid_pkg.sv
// Types shared by the nibble CPU instruction decoder
package ncid_pkg;
	// Core run state
	typedef enum logic [1:0] {
		NCID_RUN,
		NCID_HALT,
		NCID_STOP
	} ncid_state_t;
	// Peripheral control bits loaded by reset
	typedef struct packed {
		logic       remote_out_data;
		logic [1:0] timer_source_and_enable;
		logic [1:0] carrier_select;
		logic       osc_range_select;
		logic       pullup_enable;
		logic [3:0] low_voltage_detect_ctrl;
	} ncid_ctrl_t;
	// One return stack entry
	typedef struct packed {
		logic        carry;
		logic [11:0] pc;
	} ncid_stack_t;
endpackage

// ===== ncid_core.sv
// Nibble CPU decode and execute core with AHB-Lite control registers
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ncid_regs.svh"
module ncid_core #(
	parameter int RAM_DEPTH   = 128,
	parameter int STACK_DEPTH = 4
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic      [11:0]         rom_addr,
	input  wire logic [15:0]         rom_data,
	input  wire logic                ext_reset_n,
	input  wire logic                lvd_reset,
	input  wire logic                port_irq_n,
	input  wire logic                timer_irq,
	output ncid_pkg::ncid_ctrl_t     ctrl,
	output logic      [13:0]         port_dir,
	output logic                     halt_mode,
	output logic                     stop_mode
);
	// ********************************************
	// Declarations
	// ********************************************
	logic [11:0]          pc;                 // Program counter
	logic [15:0]          ir;                 // Latched instruction word
	logic [3:0]           accumulator_nibble; // Accumulator
	logic                 carry_flag;         // Carry
	logic [3:0]           table_branch_reg;   // Table branch register
	logic [1:0]           ph;                 // Phase in instruction cycle
	logic [1:0]           sp;                 // Stack pointer
	logic [15:0]          timer_reg;          // Count and reload
	logic [3:0]           ram [RAM_DEPTH];    // Data memory
	ncid_pkg::ncid_stack_t return_stack [STACK_DEPTH];
	ncid_pkg::ncid_state_t state;
	logic [2:0]           rst_sync;           // Pin reset synchroniser
	logic [2:0]           lvd_sync;           // Low-voltage reset sync
	logic [1:0]           port_sync;          // Port wake synchroniser
	logic                 soft_rst;           // Any synchronous reset
	logic                 ex_en;              // Execute enable pulse
	logic [4:0]           op;                 // Opcode field
	logic [6:0]           maddr;              // Data address field
	logic [3:0]           mx;                 // Operand from memory
	logic [3:0]           imm;                // Immediate field
	logic [11:0]          pc_inc;             // Sequential address
	logic [11:0]          br_tgt;             // Target, page kept
	logic [3:0]           next_acc;
	logic                 next_carry;
	logic                 mem_we;
	logic [3:0]           mem_wd;
	logic [11:0]          next_pc;
	logic                 push;
	logic                 pop;
	logic [1:0]           sp_top;
	// Bus slave address phase capture
	logic                 wr_pend;
	logic [7:0]           wr_ofs;
	logic                 bus_act;
	logic [31:0]          rd_mux;
	// ********************************************
	// Reset synchronisers and wake
	// ********************************************
	// External reset pin and detector are asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_sync  <= 3'h0;
			lvd_sync  <= 3'h0;
			port_sync <= 2'h3;
		end else begin
			rst_sync  <= {rst_sync[1:0], ext_reset_n};
			lvd_sync  <= {lvd_sync[1:0], lvd_reset};
			port_sync <= {port_sync[0], port_irq_n};
		end
	end
	// Stage two onward only; stage three stretches by one cycle
	assign soft_rst = !rst_sync[1] || !rst_sync[2] || lvd_sync[1] || lvd_sync[2];
	// ********************************************
	// Decode fields
	// ********************************************
	assign op     = ir[15:11];
	// Bank bits [9:7] are assumed zero and ignored
	assign maddr  = ir[6:0];
	assign mx     = ram[maddr];
	assign imm    = ir[10:7];
	assign pc_inc = pc + 12'h001;
	// Page bit kept for branches and call
	assign br_tgt = {pc[11], ir[10:0]};
	// Reset wins over execute, so no half-done instruction is ever seen
	assign ex_en  = (state == ncid_pkg::NCID_RUN) && (ph == `NCID_PH_EXEC) && !soft_rst;
	assign sp_top = sp - 2'h1;
	// ********************************************
	// Arithmetic and logic
	// ********************************************
	// One 5-bit adder per operand pair; carry is the fifth bit
	function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
		input logic ci);
		add4 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
	endfunction
	always_comb begin
		next_acc   = accumulator_nibble;
		next_carry = carry_flag;
		mem_we     = 1'b0;
		mem_wd     = 4'h0;
		unique case (op)
			`NCID_OP_ADC: begin
				{next_carry, next_acc} = add4(mx, accumulator_nibble, carry_flag);
				mem_we = ir[10];
			end
			`NCID_OP_ADD: begin
				{next_carry, next_acc} = add4(mx, accumulator_nibble, 1'b0);
				mem_we = ir[10];
			end
			`NCID_OP_SUBC: begin
				{next_carry, next_acc} = add4(mx, ~accumulator_nibble, carry_flag);
				mem_we = ir[10];
			end
			`NCID_OP_SUB: begin
				{next_carry, next_acc} = add4(mx, ~accumulator_nibble, 1'b1);
				mem_we = ir[10];
			end
			`NCID_OP_XOR: begin
				next_acc = mx ^ accumulator_nibble;
				mem_we   = ir[10];
			end
			`NCID_OP_OR: begin
				next_acc = mx | accumulator_nibble;
				mem_we   = ir[10];
			end
			`NCID_OP_AND: begin
				next_acc = mx & accumulator_nibble;
				mem_we   = ir[10];
			end
			`NCID_OP_LDST: begin
				// Load leaves memory; store leaves accumulator
				mem_we = ir[10];
				if (!ir[10]) begin
					next_acc = mx;
				end
			end
			`NCID_OP_ADDI, `NCID_OP_ADIM: begin
				{next_carry, next_acc} = add4(mx, imm, 1'b0);
				mem_we = op[0];
			end
			`NCID_OP_SUBI, `NCID_OP_SBIM: begin
				{next_carry, next_acc} = add4(mx, ~imm, 1'b1);
				mem_we = op[0];
			end
			`NCID_OP_XORI: begin
				next_acc = mx ^ imm;
				mem_we   = 1'b1;
			end
			`NCID_OP_ORI: begin
				next_acc = mx | imm;
				mem_we   = 1'b1;
			end
			`NCID_OP_ANDI: begin
				next_acc = mx & imm;
				mem_we   = 1'b1;
			end
			`NCID_OP_LDIMM: begin
				next_acc = imm;
				mem_we   = 1'b1;
			end
			default: begin
				if (ir[15:7] == `NCID_DECA_CODE) begin
					// Add six when digit above nine or carry out
					next_carry = carry_flag || (mx > `NCID_BCD_MAX);
					next_acc   = next_carry ? mx + `NCID_BCD_ADJ : mx;
					mem_we     = 1'b1;
				end else if (ir[15:7] == `NCID_DECS_CODE) begin
					// Borrow (carry clear) takes six away
					next_acc   = carry_flag ? mx : mx - `NCID_BCD_ADJ;
					mem_we     = 1'b1;
				end else if (ir == `NCID_W_SHRT) begin
					next_acc   = {1'b0, accumulator_nibble[3:1]};
					next_carry = accumulator_nibble[0];
				end else if (ir == `NCID_W_RETI) begin
					next_carry = return_stack[sp_top].carry;
				end else if (op == `NCID_OP_RET) begin
					next_acc   = ir[3:0];
				end
			end
		endcase
		// Write-back data is the accumulator result, or the current accumulator for load/store
		mem_wd = (op == `NCID_OP_LDST) ? accumulator_nibble : next_acc;
	end
	// ********************************************
	// Program counter and stack control
	// ********************************************
	always_comb begin
		next_pc = pc_inc;
		push    = 1'b0;
		pop     = 1'b0;
		unique case (op)
			`NCID_OP_BRZ:  next_pc = (accumulator_nibble == 4'h0) ? br_tgt : pc_inc;
			`NCID_OP_BRNZ: next_pc = (accumulator_nibble != 4'h0) ? br_tgt : pc_inc;
			`NCID_OP_BRC:  next_pc = carry_flag ? br_tgt : pc_inc;
			`NCID_OP_BRNC: next_pc = !carry_flag ? br_tgt : pc_inc;
			`NCID_OP_CALL: begin
				push    = 1'b1;
				next_pc = br_tgt;
			end
			`NCID_OP_RET: begin
				pop     = 1'b1;
				next_pc = return_stack[sp_top].pc;
			end
			default: begin
				if (op[4:2] == `NCID_BIT_PFX) begin
					// Bit select is the low two opcode bits
					next_pc = accumulator_nibble[op[1:0]] ? br_tgt : pc_inc;
				end else if (ir[15:12] == `NCID_JUMP_PFX) begin
					next_pc = ir[11:0];
				end else if (ir == `NCID_W_TABJ) begin
					next_pc = {pc[11:8], table_branch_reg, accumulator_nibble};
				end
			end
		endcase
	end
	// ********************************************
	// Sequencer, core registers, run state
	// ********************************************
	// Four hclk per instruction: address, latch, operand, execute
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph                 <= 2'h0;
			pc                 <= `NCID_PC_RST;
			rom_addr           <= `NCID_PC_RST;
			ir                 <= 16'hFFFF;
			accumulator_nibble <= 4'h0;
			carry_flag         <= 1'b0;
			table_branch_reg   <= 4'h0;
			sp                 <= 2'h0;
			state              <= ncid_pkg::NCID_RUN;
			halt_mode          <= 1'b0;
			stop_mode          <= 1'b0;
		end else if (soft_rst) begin
			ph        <= 2'h0;
			pc        <= `NCID_PC_RST;
			rom_addr  <= `NCID_PC_RST;
			sp        <= 2'h0;
			state     <= ncid_pkg::NCID_RUN;
			halt_mode <= 1'b0;
			stop_mode <= 1'b0;
		end else begin
			unique case (state)
				ncid_pkg::NCID_RUN: begin
					ph <= ph + 2'h1;
					if (ph == `NCID_PH_LATCH) begin
						ir <= rom_data;
					end
					if (ex_en) begin
						pc                 <= next_pc;
						rom_addr           <= next_pc;
						accumulator_nibble <= next_acc;
						carry_flag         <= next_carry;
						if (op == `NCID_OP_RET && ir != `NCID_W_RETI) begin
							table_branch_reg <= ir[7:4];
						end
						if (push) begin
							sp <= sp + 2'h1;
						end else if (pop) begin
							sp <= sp_top;
						end
						if (ir == `NCID_W_HALT) begin
							state     <= ncid_pkg::NCID_HALT;
							halt_mode <= 1'b1;
						end else if (ir == `NCID_W_STOP) begin
							state     <= ncid_pkg::NCID_STOP;
							stop_mode <= 1'b1;
						end
					end
				end
				ncid_pkg::NCID_HALT: begin
					// Timer keeps running outside; any interrupt wakes
					if (timer_irq || !port_sync[1]) begin
						state     <= ncid_pkg::NCID_RUN;
						halt_mode <= 1'b0;
					end
				end
				ncid_pkg::NCID_STOP: begin
					// Only the port wakes: the timer has no clock here
					if (!port_sync[1]) begin
						state     <= ncid_pkg::NCID_RUN;
						stop_mode <= 1'b0;
					end
				end
				default: state <= ncid_pkg::NCID_RUN;
			endcase
		end
	end
	// ********************************************
	// Data memory and return stack (no reset)
	// ********************************************
	// Contents stay undefined after reset, as on the real part
	always_ff @(posedge hclk) begin
		if (ex_en && mem_we && !soft_rst) begin
			ram[maddr] <= mem_wd;
		end
		if (ex_en && push && !soft_rst) begin
			return_stack[sp] <= '{carry: carry_flag, pc: pc_inc};
		end
	end
	// ********************************************
	// AHB-Lite register slave, zero wait states
	// ********************************************
	assign bus_act = hsel && hready && htrans[1];
	// Read data are chosen in the address phase, held in the data phase
	assign rd_mux = (haddr[7:0] == `NCID_OFS_CTRL)    ? {21'h0, ctrl} :
	                (haddr[7:0] == `NCID_OFS_PORTDIR) ? {18'h0, port_dir} :
	                (haddr[7:0] == `NCID_OFS_TIMER)   ? {16'h0, timer_reg} :
	                (haddr[7:0] == `NCID_OFS_STATUS)  ?
	                {9'h0, stop_mode, halt_mode, table_branch_reg, carry_flag,
	                 accumulator_nibble, pc} : 32'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_ofs    <= 8'h0;
		end else begin
			wr_pend <= bus_act && hwrite;
			wr_ofs  <= haddr[7:0];
			if (bus_act && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end
	// Control, direction and timer words; any reset clears them, except low_voltage_detect_ctrl, which loads NCID_LVD_RST
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl      <= '{low_voltage_detect_ctrl: `NCID_LVD_RST, default: '0};
			port_dir  <= 14'h0;
			timer_reg <= 16'h0;
		end else if (soft_rst) begin
			ctrl      <= '{low_voltage_detect_ctrl: `NCID_LVD_RST, default: '0};
			port_dir  <= 14'h0;
			timer_reg <= 16'h0;
		end else if (wr_pend) begin
			if (wr_ofs == `NCID_OFS_CTRL) begin
				ctrl <= hwdata[10:0];
			end
			if (wr_ofs == `NCID_OFS_PORTDIR) begin
				port_dir <= hwdata[13:0];
			end
			if (wr_ofs == `NCID_OFS_TIMER) begin
				timer_reg <= hwdata[15:0];
			end
		end
	end
	// ********************************************
	// Assertions
	// ********************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_one_cycle_exec: assert property (ex_en |=> !ex_en [*3])
		else $error("execute pulse repeated inside one instruction cycle");
	a_pc_on_reset: assert property (soft_rst |=> pc == 12'h000)
		else $error("program counter not zero after reset");
	a_ctrl_on_reset: assert property (soft_rst |=> ctrl == 11'h005 && port_dir == 14'h0)
		else $error("control bits wrong after reset");
	a_add_carry_sum: assert property (ex_en && op == `NCID_OP_ADC |=>
		{carry_flag, accumulator_nibble} ==
		5'({1'b0, $past(mx)} + {1'b0, $past(accumulator_nibble)} + {4'h0, $past(carry_flag)}))
		else $error("add with carry result wrong");
	a_logic_keeps_carry: assert property (ex_en && op inside {[`NCID_OP_XOR:`NCID_OP_AND]}
		|=> $stable(carry_flag))
		else $error("logic operation changed carry");
	a_shift_right_one: assert property (ex_en && ir == `NCID_W_SHRT |=>
		accumulator_nibble == {1'b0, $past(accumulator_nibble[3:1])} &&
		carry_flag == $past(accumulator_nibble[0]))
		else $error("shift right result wrong");
	a_branch_on_zero: assert property (ex_en && op == `NCID_OP_BRZ && accumulator_nibble == 4'h0
		|=> pc == {$past(pc[11]), $past(ir[10:0])})
		else $error("branch on zero not taken");
	a_jump_with_page: assert property (ex_en && ir[15:12] == `NCID_JUMP_PFX |=>
		rom_addr == $past(ir[11:0]))
		else $error("jump target wrong");
	a_table_jump_pc: assert property (ex_en && ir == `NCID_W_TABJ |=>
		pc == {$past(pc[11:8]), $past(table_branch_reg), $past(accumulator_nibble)})
		else $error("table jump target wrong");
	a_halt_holds_pc: assert property (state == ncid_pkg::NCID_HALT && !soft_rst |=>
		$stable(pc) [*2])
		else $error("program counter moved while halted");
	c_call_return: cover property (ex_en && op == `NCID_OP_CALL ##[4:40] ex_en && op == `NCID_OP_RET);
	c_halt_wake: cover property (halt_mode ##1 !halt_mode);
	c_stop_wake: cover property (stop_mode ##1 !stop_mode);
endmodule

// ===== ncid_rom_model.sv
// Program ROM model that answers the decoder's fetch port
`timescale 1ns/10ps
module ncid_rom_model (
	input  wire logic        hclk,
	input  wire logic [11:0] rom_addr,
	output logic      [15:0] rom_data
);
	logic [15:0] mem [0:4095]; // Program words, loaded by the bench
	logic [11:0] last_addr;    // Address seen at the previous edge
	// Remember the address one edge back
	always_ff @(posedge hclk) begin
		last_addr <= rom_addr;
	end
	// Word is only good from the second edge on; before that it shows junk
	assign rom_data = (rom_addr == last_addr) ? mem[rom_addr] : ~mem[rom_addr];
endmodule

// ===== nibble_cpu_instruction_decode_tb_top.sv
// Self-checking bench for the nibble CPU decoder
`timescale 1ns/10ps
module nibble_cpu_instruction_decode_tb_top;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_reset_n = 1, lvd_reset = 0;
	logic        port_irq_n = 1, timer_irq = 0, hreadyout, hresp, halt_mode, stop_mode, t;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_word;
	logic [11:0] rom_addr;
	logic [15:0] rom_data, tw;
	logic [13:0] port_dir;
	ncid_pkg::ncid_ctrl_t ctrl;
	int          error_cnt = 0, compares = 0, m, a, c, i, w, k, s, na, nc, nm;
	always #2 hclk = ~hclk;
	ncid_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rom_addr(rom_addr), .rom_data(rom_data), .ext_reset_n(ext_reset_n),
		.lvd_reset(lvd_reset), .port_irq_n(port_irq_n), .timer_irq(timer_irq),
		.ctrl(ctrl), .port_dir(port_dir), .halt_mode(halt_mode), .stop_mode(stop_mode));
	ncid_rom_model rom (.hclk(hclk), .rom_addr(rom_addr), .rom_data(rom_data));
	// Verdict and end of run
	task automatic stop_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Compare and count
	task automatic chk(input string nam, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nam, exp, seen);
		end
	endtask
	// Wait for hready high at an edge, bounded
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			stop_test();
		end
	endtask
	// One AHB single word transfer; read data lands in rd_word
	task automatic bus(input logic [7:0] adr, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, adr};
		hwrite <= wr;
		rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdy();
		rd_word = hrdata;
	endtask
	// Wait for halt (0) or stop (1), bounded
	task automatic wait_for(input int which);
		int n;
		for (n = 0; n < 500 && (which ? stop_mode : halt_mode) !== 1'b1; n++) @(posedge hclk);
		if (n >= 500) begin
			error_cnt++;
			stop_test();
		end
	endtask
	// Load program around test word, reset, run to halt, read status
	task automatic run(input logic [15:0] w5, input logic [15:0] w20, input int which);
		rom.mem[0] = {5'h0F, 4'hF, 7'h12};
		rom.mem[1] = {5'h0F, 4'(c), 7'h13};
		rom.mem[2] = 16'h0812; // Carry becomes c
		rom.mem[3] = {5'h0F, 4'(m), 7'h11};
		rom.mem[4] = {5'h0F, 4'(a), 7'h13};
		rom.mem[5] = w5;
		rom.mem[6] = 16'hD800;
		rom.mem[7] = 16'h3811;
		rom.mem[8] = 16'hD800;
		rom.mem[10] = {5'h0F, 4'hA, 7'h13};
		rom.mem[11] = 16'hD800;
		rom.mem[20] = w20;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("pc_rst", rom_addr, 0);
		hresetn <= 1'b1;
		wait_for(which);
		if (which) begin
			port_irq_n <= 1'b0;
			repeat (4) @(posedge hclk);
			port_irq_n <= 1'b1;
			repeat (2) @(posedge hclk);
			wait_for(0);
		end
		bus(8'h0C, 0, 0);
	endtask
	initial begin
		for (k = 0; k < 4096; k++) rom.mem[k] = 16'hFFFF;
		void'($urandom(32'h6672));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(8'h00, 0, 0);
		chk("ctrl", {port_dir, 7'h0, ctrl}, 32'h0000_0005);
		bus(8'h40, 0, 0);
		chk("unmapped", rd_word, 0);
		// Sync resets from the low-voltage and the pin source
		for (k = 0; k < 2; k++) begin
			bus(8'h08, 1, 32'h0000_A5C3);
			bus(8'h04, 1, 32'h0000_3FFF);
			bus(8'h00, 1, 32'h0000_07FA);
			// Written values must land, or the reset checks below prove nothing
			bus(8'h08, 0, 0);
			chk("timer_wr", rd_word, 32'h0000_A5C3);
			chk("ctrl_wr", {port_dir, 7'h0, ctrl}, 32'hFFFC_07FA);
			ext_reset_n <= k[0] ? 1'b0 : 1'b1;
			lvd_reset <= !k[0];
			repeat (3) @(posedge hclk);
			ext_reset_n <= 1'b1;
			lvd_reset <= 1'b0;
			repeat (4) @(posedge hclk);
			chk("ctrl_sync", {port_dir, 7'h0, ctrl}, 32'h0000_0005);
			bus(8'h08, 0, 0);
			chk("timer", rd_word, 0);
		end
		// Random arithmetic, logic and transfer words against the model
		for (k = 0; k < 38; k++) begin
			m = $urandom % 16;
			a = $urandom % 16;
			c = $urandom % 2;
			i = $urandom % 16;
			w = $urandom % 2;
			s = k % 19;
			tw = s < 8 ? {5'(s), 1'(w), 3'h0, 7'h11} : s < 16 ? {5'(s), 4'(i), 7'h11} :
				s == 16 ? 16'hF000 : s == 17 ? 16'hCB11 : 16'hCD11;
			nc = c;
			nm = m;
			na = a;
			case (s)
				0, 1, 2, 3: na = m + (s > 1 ? ~a & 15 : a) + (s == 1 ? 0 : s == 3 ? 1 : c);
				4: na = m ^ a;
				5: na = m | a;
				6: na = m & a;
				7: na = w ? a : m;
				8, 9, 10, 11: na = m + (s > 9 ? (~i & 15) + 1 : i);
				12: na = m ^ i;
				13: na = m | i;
				14: na = m & i;
				15: na = i;
				16: na = a >> 1;
				17: na = (m > 9 || c) ? m + 6 : m;
				default: na = c ? m : m - 6;
			endcase
			if (s < 4 || (s > 7 && s < 12)) nc = na >> 4;
			if (s == 16) nc = a & 1;
			if (s == 17) nc = m > 9 || c;
			na = na & 15;
			if ((s < 7 && w) || s > 8 && s != 10 && s != 16) nm = na;
			if (s == 7) nm = w ? a : m;
			run(tw, 16'hFFFF, 0);
			chk("acc", rd_word >> 12 & 15, na);
			chk("carry", rd_word >> 16 & 1, nc);
			timer_irq <= 1'b1;
			repeat (2) @(posedge hclk);
			timer_irq <= 1'b0;
			repeat (2) @(posedge hclk);
			wait_for(0);
			bus(8'h0C, 0, 0);
			chk("mem", rd_word >> 12 & 15, nm);
		end
		// Branches, jump, call with both returns, no-op and stop
		for (k = 0; k < 26; k++) begin
			a = $urandom % 16;
			c = $urandom % 2;
			m = $urandom % 16;
			i = $urandom % 16;
			w = $urandom % 16;
			s = k % 13;
			tw = s < 8 ? {5'(s + 16), 11'h00A} : s == 8 ? 16'hE00A : s == 11 ? 16'hFFFF :
				s == 12 ? 16'hDC00 : 16'hC014;
			t = s == 0 ? a != 0 : s == 1 ? !c : s == 2 ? a == 0 : s == 3 ? c[0] :
				s < 8 ? a[s - 4] : s == 8;
			run(tw, s == 9 ? {8'hD0, 4'(i), 4'(w)} : 16'hD400, s == 12);
			chk("branch_acc", rd_word >> 12 & 15, s == 9 ? w : t ? 10 : a);
			chk("ret_carry", rd_word >> 16 & 1, c);
			if (s == 9) chk("table", rd_word >> 17 & 15, i);
		end
		stop_test();
	end
endmodule
